// [logic/crxf_pkg.sv]
// Package with register map, reset values and field layout of the receive filter slice.
package crxf_pkg;
    localparam int NUM_BUF = 8;
    localparam int ID_W = 29;
    localparam int STD_W = 11;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FORMAT_SEL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MASK_ZERO = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_MASK_ONE = 4'hC;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [15:0] RST_FORMAT_SEL = 16'h0000;
    localparam logic [ID_W-1:0] RST_MASK = 29'h00000000;
    localparam logic [ID_W-1:0] STD_KEEP = 29'h1FFC0000;
    localparam logic [1:0] FMT_FULL_CMP = 2'h0;
    localparam logic [1:0] FMT_FULL_MASK = 2'h1;
    localparam logic [1:0] FMT_MASK_ZERO = 2'h2;
    localparam logic [1:0] FMT_MASK_ONE = 2'h3;
endpackage

// [logic/crxf_buf_filter.sv]
// Acceptance filter of one message buffer.
`timescale 1ns/100ps
`default_nettype none
module crxf_buf_filter
    import crxf_pkg::*;
(
    input wire logic [1:0] format_sel,
    input wire logic extended,
    input wire logic [ID_W-1:0] rx_id,
    input wire logic [ID_W-1:0] buf_id,
    input wire logic [ID_W-1:0] shared_mask_zero,
    input wire logic [ID_W-1:0] shared_mask_one,
    output logic pass
);
    wire logic [ID_W-1:0] sel_mask;
    wire logic [ID_W-1:0] span;
    wire logic [ID_W-1:0] cmp_bits;
    // A set bit in sel_mask excludes that identifier bit.
    assign sel_mask = (format_sel == FMT_FULL_CMP) ? '0 :
                      (format_sel == FMT_FULL_MASK) ? '1 :
                      (format_sel == FMT_MASK_ZERO) ? shared_mask_zero :
                      shared_mask_one;
    assign span = extended ? '1 : STD_KEEP;
    assign cmp_bits = ~sel_mask & span;
    assign pass = ((rx_id ^ buf_id) & cmp_bits) == '0;
endmodule
`default_nettype wire

// [logic/crxf_top.sv]
// Receive filter select and receive interrupt enable slice with Avalon-MM slave.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module crxf_top
    import crxf_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [crxf_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [crxf_pkg::NUM_BUF-1:0] rx_complete_flag,
    input wire logic [crxf_pkg::NUM_BUF-1:0] extended_format_bit,
    input wire logic [crxf_pkg::NUM_BUF-1:0] buffer_valid_bit,
    input wire logic [crxf_pkg::NUM_BUF*crxf_pkg::ID_W-1:0] buffer_identifier,
    input wire logic [crxf_pkg::ID_W-1:0] rx_id,
    input wire logic rx_id_valid,
    output logic rx_irq,
    output logic [crxf_pkg::NUM_BUF-1:0] rx_irq_per_buf,
    output logic accept_valid,
    output logic accept_hit,
    output logic [2:0] accept_buf
);
    logic [7:0] rx_complete_irq_enable_q;
    logic [15:0] filter_format_select_q;
    logic [ID_W-1:0] shared_mask_zero_q;
    logic [ID_W-1:0] shared_mask_one_q;
    logic ack_q;
    wire logic [NUM_BUF-1:0] pass_raw;
    wire logic [NUM_BUF-1:0] pass_vec;
    wire logic [NUM_BUF-1:0] irq_vec;
    wire logic access;
    wire logic wr_fire;
    wire logic wr_en_reg;
    wire logic wr_fmt_reg;
    wire logic wr_m0_reg;
    wire logic wr_m1_reg;
    wire logic [31:0] rd_mux;
    wire logic [31:0] m0_next;
    wire logic [31:0] m1_next;
    wire logic [15:0] fmt_next;
    wire logic [31:0] wmask;
    logic [2:0] first_idx;
    logic first_hit;

    genvar g;
    generate
        for (g = 0; g < NUM_BUF; g++) begin : g_flt
            crxf_buf_filter u_flt (
                .format_sel(filter_format_select_q[2*g+1:2*g]),
                .extended(extended_format_bit[g]),
                .rx_id(rx_id),
                .buf_id(buffer_identifier[g*ID_W +: ID_W]),
                .shared_mask_zero(shared_mask_zero_q),
                .shared_mask_one(shared_mask_one_q),
                .pass(pass_raw[g])
            );
        end
    endgenerate

    // Only enabled buffers take part in acceptance; interrupts ignore buffer_valid_bit; selectors are changed while disabled.
    assign pass_vec = pass_raw & buffer_valid_bit;
    assign irq_vec = rx_complete_flag & rx_complete_irq_enable_q;

    // Lowest numbered passing buffer wins.
    always_comb begin
        first_idx = 3'h0;
        first_hit = 1'b0;
        for (int i = NUM_BUF - 1; i >= 0; i--) begin
            if (pass_vec[i]) begin
                first_idx = 3'(i);
                first_hit = 1'b1;
            end
        end
    end

    // Every access is answered one cycle after it is presented.
    assign access = (avs_read | avs_write) & ~ack_q;
    assign wr_fire = avs_write & ack_q;
    assign wr_en_reg = wr_fire & (avs_address == OFS_IRQ_ENABLE);
    assign wr_fmt_reg = wr_fire & (avs_address == OFS_FORMAT_SEL);
    assign wr_m0_reg = wr_fire & (avs_address == OFS_MASK_ZERO);
    assign wr_m1_reg = wr_fire & (avs_address == OFS_MASK_ONE);
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign fmt_next = (avs_writedata[15:0] & wmask[15:0])
                    | (filter_format_select_q & ~wmask[15:0]);
    assign m0_next = (avs_writedata & wmask) | ({3'h0, shared_mask_zero_q} & ~wmask);
    assign m1_next = (avs_writedata & wmask) | ({3'h0, shared_mask_one_q} & ~wmask);
    assign rd_mux = (avs_address == OFS_IRQ_ENABLE) ? {24'h000000, rx_complete_irq_enable_q} :
                    (avs_address == OFS_FORMAT_SEL) ? {16'h0000, filter_format_select_q} :
                    (avs_address == OFS_MASK_ZERO) ? {3'h0, shared_mask_zero_q} :
                    (avs_address == OFS_MASK_ONE) ? {3'h0, shared_mask_one_q} :
                    32'h00000000;

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            ack_q <= access;
            avs_waitrequest <= ~access;
            avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_complete_irq_enable_q <= RST_IRQ_ENABLE;
            filter_format_select_q <= RST_FORMAT_SEL;
            shared_mask_zero_q <= RST_MASK;
            shared_mask_one_q <= RST_MASK;
        end else begin
            if (wr_en_reg && avs_byteenable[0]) begin
                rx_complete_irq_enable_q <= avs_writedata[7:0];
            end
            if (wr_fmt_reg) begin
                filter_format_select_q <= fmt_next;
            end
            if (wr_m0_reg) begin
                shared_mask_zero_q <= m0_next[ID_W-1:0];
            end
            if (wr_m1_reg) begin
                shared_mask_one_q <= m1_next[ID_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_irq <= 1'b0;
            rx_irq_per_buf <= '0;
            accept_valid <= 1'b0;
            accept_hit <= 1'b0;
            accept_buf <= 3'h0;
        end else begin
            rx_irq <= |irq_vec;
            rx_irq_per_buf <= irq_vec;
            accept_valid <= rx_id_valid;
            accept_hit <= rx_id_valid & first_hit;
            accept_buf <= first_idx;
        end
    end

    property p_irq_gate;
        @(posedge clk) disable iff (srst)
        1'b1 |=> (rx_irq_per_buf == $past(rx_complete_flag & rx_complete_irq_enable_q));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("per-buffer request mismatch");

    property p_irq_or;
        @(posedge clk) disable iff (srst)
        (|(rx_complete_flag & rx_complete_irq_enable_q)) |=> rx_irq;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("request missing");

    property p_irq_none;
        @(posedge clk) disable iff (srst)
        (rx_complete_irq_enable_q == 8'h00) |=> !rx_irq;
    endproperty
    a_irq_none: assert property (p_irq_none) else $error("request with no enable");

    property p_fmt_write;
        @(posedge clk) disable iff (srst)
        (wr_fmt_reg && avs_byteenable == 4'hF) |=> filter_format_select_q == $past(avs_writedata[15:0]);
    endproperty
    a_fmt_write: assert property (p_fmt_write) else $error("selector write lost");

    property p_prio;
        @(posedge clk) disable iff (srst)
        (rx_id_valid && first_hit) |=> (accept_hit
            && (($past(pass_vec) >> accept_buf) & 8'h01) == 8'h01
            && ($past(pass_vec) & ((8'h01 << accept_buf) - 8'h01)) == 8'h00);
    endproperty
    a_prio: assert property (p_prio) else $error("lowest passing buffer not chosen");

    property p_full_cmp;
        @(posedge clk) disable iff (srst)
        (filter_format_select_q[1:0] == FMT_FULL_CMP && extended_format_bit[0]
            && rx_id != buffer_identifier[ID_W-1:0]) |-> !pass_raw[0];
    endproperty
    a_full_cmp: assert property (p_full_cmp) else $error("full compare passed a mismatch");

    property p_full_mask;
        @(posedge clk) disable iff (srst)
        (filter_format_select_q[1:0] == FMT_FULL_MASK) |-> pass_raw[0];
    endproperty
    a_full_mask: assert property (p_full_mask) else $error("full mask rejected");

    property p_std_span;
        @(posedge clk) disable iff (srst)
        (!extended_format_bit[0] && filter_format_select_q[1:0] == FMT_FULL_CMP
            && ((rx_id ^ buffer_identifier[ID_W-1:0]) & STD_KEEP) == '0) |-> pass_raw[0];
    endproperty
    a_std_span: assert property (p_std_span) else $error("standard span wrong");

    property p_mask0;
        @(posedge clk) disable iff (srst)
        (filter_format_select_q[1:0] == FMT_MASK_ZERO && extended_format_bit[0]
            && ((rx_id ^ buffer_identifier[ID_W-1:0]) & ~shared_mask_zero_q) != '0) |-> !pass_raw[0];
    endproperty
    a_mask0: assert property (p_mask0) else $error("shared mask zero ignored");

    property p_wait;
        @(posedge clk) disable iff (srst)
        ((avs_read || avs_write) && avs_waitrequest) |-> ##[0:1] !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");

    property p_mask1;
        @(posedge clk) disable iff (srst)
        (filter_format_select_q[1:0] == FMT_MASK_ONE && extended_format_bit[0]
            && ((rx_id ^ buffer_identifier[ID_W-1:0]) & ~shared_mask_one_q) != '0) |-> !pass_raw[0];
    endproperty
    a_mask1: assert property (p_mask1) else $error("shared mask one ignored");

    // Outputs show their idle values in the cycle after any reset edge.
    property p_rst_idle;
        @(posedge clk)
        srst |=> (avs_waitrequest && !rx_irq && rx_irq_per_buf == 8'h00 && !accept_valid
            && !accept_hit && avs_readdata == 32'h00000000);
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// [verification/crxf_top_tb.sv]
// Self-checking testbench of the receive filter slice with random and corner stimulus.
`timescale 1ns/100ps
`default_nettype none
module crxf_top_tb;
    import crxf_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [NUM_BUF-1:0] rx_complete_flag = '0;
    logic [NUM_BUF-1:0] extended_format_bit = '0;
    logic [NUM_BUF-1:0] buffer_valid_bit = '0;
    logic [NUM_BUF*ID_W-1:0] buffer_identifier = '0;
    logic [ID_W-1:0] rx_id = '0;
    logic rx_id_valid = 1'b0;
    logic rx_irq;
    logic [NUM_BUF-1:0] rx_irq_per_buf;
    logic accept_valid;
    logic accept_hit;
    logic [2:0] accept_buf;
    logic [31:0] d;
    logic [31:0] rd;
    logic [7:0] e_en = 8'h00;
    logic [15:0] e_fmt = 16'h0000;
    logic [ID_W-1:0] e_m0 = '0;
    logic [ID_W-1:0] e_m1 = '0;
    logic [ID_W-1:0] base;
    int err_total = 0;
    int check_count = 0;
    crxf_top crxf_top_i (.clk(clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_complete_flag(rx_complete_flag),
        .extended_format_bit(extended_format_bit), .buffer_valid_bit(buffer_valid_bit),
        .buffer_identifier(buffer_identifier), .rx_id(rx_id), .rx_id_valid(rx_id_valid),
        .rx_irq(rx_irq), .rx_irq_per_buf(rx_irq_per_buf), .accept_valid(accept_valid),
        .accept_hit(accept_hit), .accept_buf(accept_buf));
    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    function automatic logic [7:0] expect_accept();
        logic [ID_W-1:0] msk;
        logic [ID_W-1:0] cmp;
        logic [7:0] r;
        r = 8'h00;
        for (int b = NUM_BUF - 1; b >= 0; b--) begin
            case (e_fmt[2*b +: 2])
                FMT_FULL_CMP: msk = '0;
                FMT_FULL_MASK: msk = '1;
                FMT_MASK_ZERO: msk = e_m0;
                default: msk = e_m1;
            endcase
            cmp = ~msk & (extended_format_bit[b] ? {ID_W{1'b1}} : STD_KEEP);
            if (buffer_valid_bit[b] && ((rx_id ^ buffer_identifier[b*ID_W +: ID_W]) & cmp) == '0)
                r = {4'h0, 1'b1, 3'(b)};
        end
        return r;
    endfunction
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        #1000000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h7ee8ceb5));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 16; a += 4) begin
            bus(1'b0, 4'(a), 32'h0, 4'hF);
            chk_reg(rd, 32'h0);
        end
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            buffer_valid_bit <= 8'h00;
            d = $urandom;
            bus(1'b1, OFS_MASK_ZERO, d, 4'hF);
            e_m0 = d[ID_W-1:0];
            d = $urandom;
            bus(1'b1, OFS_MASK_ONE, d, 4'hF);
            e_m1 = d[ID_W-1:0];
            d = (i == 0) ? 32'h0000E4E4 : $urandom;
            bus(1'b1, OFS_FORMAT_SEL, d, 4'hF);
            e_fmt = d[15:0];
            d = $urandom;
            bus(1'b1, OFS_FORMAT_SEL, d, 4'h2);
            e_fmt[15:8] = d[15:8];
            bus(1'b1, 4'h6, $urandom, 4'hF);
            d = (i == 1) ? 32'h00000000 : (i == 2) ? 32'h000000FF : $urandom;
            bus(1'b1, OFS_IRQ_ENABLE, d, 4'hF);
            e_en = d[7:0];
            bus(1'b0, OFS_FORMAT_SEL, 32'h0, 4'hF);
            chk_reg(rd, {16'h0, e_fmt});
            bus(1'b0, OFS_IRQ_ENABLE, 32'h0, 4'hF);
            chk_reg(rd, {24'h0, e_en});
            bus(1'b0, 4'h6, 32'h0, 4'hF);
            chk_reg(rd, 32'h0);
            for (int k = 0; k < 8; k++) begin
                @(posedge clk);
                base = ID_W'($urandom);
                for (int b = 0; b < NUM_BUF; b++) begin
                    buffer_identifier[b*ID_W +: ID_W] <= base ^ ID_W'(($urandom & 3) << 18)
                        ^ ID_W'($urandom & 3);
                end
                rx_id <= base ^ ID_W'($urandom & 1) ^ ID_W'(($urandom & 1) << 18);
                rx_complete_flag <= 8'($urandom);
                extended_format_bit <= 8'($urandom);
                buffer_valid_bit <= 8'($urandom) | 8'($urandom);
                rx_id_valid <= ($urandom % 4) != 0;
                repeat (2) @(posedge clk);
                @(negedge clk);
                chk_out(rx_irq_per_buf, rx_complete_flag & e_en);
                chk_out({7'h0, rx_irq}, {7'h0, |(rx_complete_flag & e_en)});
                chk_out({7'h0, accept_valid}, {7'h0, rx_id_valid});
                if (rx_id_valid) chk_out({4'h0, accept_hit, accept_buf}, expect_accept());
                else chk_out({7'h0, accept_hit}, 8'h00);
            end
        end
        // A second reset in mid-run must bring the format select and interrupt enable registers back to their reset values.
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        bus(1'b0, OFS_FORMAT_SEL, 32'h0, 4'hF);
        chk_reg(rd, {16'h0, RST_FORMAT_SEL});
        bus(1'b0, OFS_IRQ_ENABLE, 32'h0, 4'hF);
        chk_reg(rd, {24'h0, RST_IRQ_ENABLE});
        tally_and_finish();
    end
endmodule
`default_nettype wire
